// >>> hw/dual_adc_digital_output.sv
// module: pipelined digital output stage of a dual 12-bit converter
//
// How it works
// - both channels sampled on one rising edge
// - flag low in range, high outside
// - flag travels with its own data word
// - enable high releases that channel's outputs
// - straight offset binary, zero is msb only
// - half scales give C00 and 400 hex
// - two parallel words, each own flag
`timescale 1ns/100ps
module dual_adc_digital_output #(
	parameter int unsigned LATENCY = adc_out_pkg::LATENCY_DEF
) (
	// clock, reset, enable
	input  wire logic                clk_i,
	input  wire logic                reset_i,
	input  wire logic                ce_i,
	// quantiser results, both channels
	input  wire adc_out_pkg::sample_s samp_a_i,
	input  wire adc_out_pkg::sample_s samp_b_i,
	// output enables, active low
	input  wire logic                oe_a_n_i,
	input  wire logic                oe_b_n_i,
	// capture side handshake
	input  wire logic                ready_i,
	output logic                     valid_o,
	// channel a pins
	output logic [11:0]              data_a_o,
	output logic [11:0]              data_a_oe_o,
	output logic                     over_range_flag_a_o,
	output logic                     over_range_flag_a_oe_o,
	// channel b pins
	output logic [11:0]              data_b_o,
	output logic [11:0]              data_b_oe_o,
	output logic                     over_range_flag_b_o,
	output logic                     over_range_flag_b_oe_o
);

	// refused at elaboration: one stage is the least the chain can hold
	if (LATENCY < 2 || LATENCY > 64)
	begin : g_bad_latency
		$error("LATENCY must lie between 2 and 64");
	end

	// ****************************************************************
	// coding
	// ****************************************************************
	// clamp on over range; offset binary is two's complement with msb flipped
	function automatic adc_out_pkg::result_s code_sample(input adc_out_pkg::sample_s s);
		adc_out_pkg::result_s r;
		r.word            = {~s.raw[adc_out_pkg::MSB_POS], s.raw[10:0]};
		r.over_range_flag = s.above | s.below;
		if (s.above)
			r.word = adc_out_pkg::CODE_POS_FS;
		else if (s.below)
			r.word = adc_out_pkg::CODE_NEG_FS;
		return r;
	endfunction : code_sample

	// both channels coded and joined on one edge, no per-channel timing
	wire adc_out_pkg::pair_s taken_w = '{a: code_sample(samp_a_i), b: code_sample(samp_b_i)};

	// ****************************************************************
	// pipeline
	// ****************************************************************
	// flag and word share one stage chain, so they cannot drift apart
	adc_out_pkg::pair_s pipe_q [LATENCY-1];
	logic               pvld_q [LATENCY-1];

	// ****************************************************************
	// two-entry buffer
	// ****************************************************************
	adc_out_pkg::pair_s buf_q [2];
	logic [1:0]         cnt_q;
	logic               rd_q;
	logic               wr_q;

	wire logic stage_vld_w = pvld_q[LATENCY-2];
	wire logic out_load_w  = !valid_o || ready_i;
	wire logic pop_w       = (cnt_q != 2'h0) && out_load_w;
	wire logic full_w      = (cnt_q == 2'h2);
	// stall holds the pipeline; analog sampling itself cannot stop, so a
	// held receiver freezes the digital chain, and samples presented meanwhile are dropped
	wire logic adv_w       = ce_i && !(full_w && !pop_w);
	wire logic push_w      = adv_w && stage_vld_w;
	wire adc_out_pkg::pair_s head_w = buf_q[rd_q];
	wire logic [1:0] cnt_d = cnt_q + {1'b0, push_w} - {1'b0, pop_w};

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			for (int i = 0; i < LATENCY-1; i++)
			begin
				pipe_q[i] <= '0;
				pvld_q[i] <= 1'b0;
			end
		end
		else if (adv_w)
		begin
			pipe_q[0] <= taken_w;
			pvld_q[0] <= 1'b1;
			for (int i = 1; i < LATENCY-1; i++)
			begin
				pipe_q[i] <= pipe_q[i-1];
				pvld_q[i] <= pvld_q[i-1];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			cnt_q    <= 2'h0;
			rd_q     <= 1'b0;
			wr_q     <= 1'b0;
		end
		else if (ce_i)
		begin
			if (push_w)
			begin
				buf_q[wr_q] <= pipe_q[LATENCY-2];
				wr_q        <= ~wr_q;
			end
			if (pop_w)
				rd_q <= ~rd_q;
			cnt_q <= cnt_d;
		end
	end

	// ****************************************************************
	// output pins
	// ****************************************************************
	// a new pair moves out only on an edge the receiver has freed
	wire logic                 show_w   = ce_i && out_load_w;
	wire logic                 have_w   = (cnt_q != 2'h0);
	wire logic                 load_w   = show_w && have_w;
	wire adc_out_pkg::result_s head_a_w = head_w.a;
	wire adc_out_pkg::result_s head_b_w = head_w.b;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			valid_o <= 1'b0;
		else if (show_w)
			valid_o <= have_w;
	end

	// word and flag share one load, so they never part
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			data_a_o            <= adc_out_pkg::RESET_WORD;
			over_range_flag_a_o <= 1'b0;
		end
		else if (load_w)
		begin
			data_a_o            <= head_a_w.word;
			over_range_flag_a_o <= head_a_w.over_range_flag;
		end
	end

	// channel b, same edge as channel a
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			data_b_o            <= adc_out_pkg::RESET_WORD;
			over_range_flag_b_o <= 1'b0;
		end
		else if (load_w)
		begin
			data_b_o            <= head_b_w.word;
			over_range_flag_b_o <= head_b_w.over_range_flag;
		end
	end

	// ****************************************************************
	// drive enables
	// ****************************************************************
	// registered so every pin comes from a flip-flop; costs one cycle of lag
	wire logic drive_a_w = ~oe_a_n_i;
	wire logic drive_b_w = ~oe_b_n_i;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			data_a_oe_o            <= 12'h000;
			over_range_flag_a_oe_o <= 1'b0;
		end
		else if (ce_i)
		begin
			data_a_oe_o            <= {12{drive_a_w}};
			over_range_flag_a_oe_o <= drive_a_w;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			data_b_oe_o            <= 12'h000;
			over_range_flag_b_oe_o <= 1'b0;
		end
		else if (ce_i)
		begin
			data_b_oe_o            <= {12{drive_b_w}};
			over_range_flag_b_oe_o <= drive_b_w;
		end
	end

endmodule : dual_adc_digital_output

// >>> hw/adc_out_pkg.sv
// package: shared constants and carrier types of the dual converter output block
package adc_out_pkg;

	// ****************************************************************
	// word layout and coding
	// ****************************************************************
	localparam int unsigned WORD_WIDTH   = 12;
	localparam int unsigned MSB_POS      = 11;
	localparam int unsigned LATENCY_DEF  = 6;
	localparam logic [11:0] CODE_POS_FS  = 12'hFFF;
	localparam logic [11:0] CODE_POS_HF  = 12'hC00;
	localparam logic [11:0] CODE_ZERO    = 12'h800;
	localparam logic [11:0] CODE_NEG_HF  = 12'h400;
	localparam logic [11:0] CODE_NEG_FS  = 12'h000;
	localparam logic [11:0] RESET_WORD   = 12'h800;

	// ****************************************************************
	// carriers
	// ****************************************************************
	// one channel's raw quantiser result, two's complement, plus range status
	typedef struct packed {
		logic [11:0] raw;
		logic        above;
		logic        below;
	} sample_s;

	// one channel's delivered result
	typedef struct packed {
		logic [11:0] word;
		logic        over_range_flag;
	} result_s;

	// both channels taken on one edge
	typedef struct packed {
		result_s a;
		result_s b;
	} pair_s;

endpackage : adc_out_pkg

// >>> verif/adc_out_chk.sv
// checker: port assertions of the converter output block
`timescale 1ns/100ps
module adc_out_chk (
	// clock, reset, enable
	input wire logic                 clk_i,
	input wire logic                 reset_i,
	input wire logic                 ce_i,
	// controls and samples
	input wire logic                 ready_i,
	input wire logic                 oe_a_n_i,
	input wire logic                 oe_b_n_i,
	input wire adc_out_pkg::sample_s samp_a_i,
	// outputs watched
	input wire logic                 valid_o,
	input wire logic [11:0]          data_a_o,
	input wire logic [11:0]          data_b_o,
	input wire logic [11:0]          data_a_oe_o,
	input wire logic [11:0]          data_b_oe_o,
	input wire logic                 over_range_flag_a_o,
	input wire logic                 over_range_flag_b_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_oe_a_on: assert property (ce_i && !oe_a_n_i |=> data_a_oe_o == 12'hFFF)
		else $error("oe a");
	a_oe_a_off: assert property (ce_i && oe_a_n_i |=> data_a_oe_o == 12'h000)
		else $error("hiz a");
	a_oe_b_on: assert property (ce_i && !oe_b_n_i |=> data_b_oe_o == 12'hFFF)
		else $error("oe b");
	a_oe_b_off: assert property (ce_i && oe_b_n_i |=> data_b_oe_o == 12'h000)
		else $error("hiz b");
	a_clip_a: assert property
		(over_range_flag_a_o |-> data_a_o inside {12'hFFF, 12'h000}) else $error("clip a");
	a_clip_b: assert property
		(over_range_flag_b_o |-> data_b_o inside {12'hFFF, 12'h000}) else $error("clip b");
	a_stall_hold: assert property
		(valid_o && !ready_i |=> valid_o && $stable({data_a_o, data_b_o})) else $error("stall");
	// counts fixed for a latency of two stages: word seen three edges after its sample
	a_no_early: assert property
		($fell(reset_i) |-> !valid_o ##1 !valid_o ##1 !valid_o) else $error("early");
	a_lat_a: assert property
		($fell(reset_i) ##0 (ce_i && ready_i)[*4] |=> valid_o && (data_a_o ^ 12'h800) ==
		$past(samp_a_i.raw, 3)) else $error("latency");
	c_stall: cover property (valid_o && !ready_i);
	c_clip: cover property (over_range_flag_b_o);
	c_hiz: cover property (oe_a_n_i ##2 data_a_oe_o == 12'h000);
endmodule : adc_out_chk
bind dual_adc_digital_output adc_out_chk chk_i (.clk_i, .reset_i, .ce_i, .ready_i, .oe_a_n_i,
	.oe_b_n_i, .valid_o, .samp_a_i, .data_a_o, .data_b_o, .data_a_oe_o, .data_b_oe_o,
	.over_range_flag_a_o, .over_range_flag_b_o);

// >>> verif/capture_model.sv
// partner: capture logic latching both channel words
`timescale 1ns/100ps
module capture_model (
	// clock and stall request
	input  wire logic               clk_i,
	input  wire logic               hold_i,
	// block side
	input  wire logic               valid_i,
	input  wire adc_out_pkg::pair_s pins_i,
	input  wire logic [11:0]        oe_a_i,
	// handshake and captured pair
	output logic                    ready_o,
	output adc_out_pkg::pair_s      cap_o
);
	logic [11:0] seen_q = 12'h000;
	// a released line shows its last level inverted, never a lucky match
	wire [11:0] line_a = (pins_i.a.word & oe_a_i) | (~seen_q & ~oe_a_i);
	assign ready_o = !hold_i;
	always_ff @(posedge clk_i)
	begin
		seen_q <= line_a;
		if (valid_i && ready_o)
			cap_o <= {~line_a[11], line_a[10:0], pins_i.a.over_range_flag, ~pins_i.b.word[11],
				pins_i.b.word[10:0], pins_i.b.over_range_flag};
	end
endmodule : capture_model

// >>> verif/testbench.sv
// testbench: self-checking run of the converter output block
`timescale 1ns/100ps
module testbench;
	logic clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, hold = 1'b0;
	// enables low at rest, as the pull-down leaves an open pin
	logic oe_a_n_i = 1'b0, oe_b_n_i = 1'b0;
	adc_out_pkg::sample_s samp_a_i = '0, samp_b_i = '0;
	wire adc_out_pkg::pair_s pins;
	adc_out_pkg::pair_s cap;
	logic valid_o, ready_i;
	logic [11:0] oe_a, oe_b;
	logic fl_oe_a, fl_oe_b;
	int err_total = 0, tests_run = 0;
	dual_adc_digital_output #(.LATENCY(2)) dual_adc_digital_output_i (.clk_i, .reset_i, .ce_i,
		.samp_a_i, .samp_b_i, .oe_a_n_i, .oe_b_n_i, .ready_i, .valid_o, .data_a_o(pins.a.word),
		.data_a_oe_o(oe_a), .over_range_flag_a_o(pins.a.over_range_flag),
		.over_range_flag_a_oe_o(fl_oe_a), .data_b_o(pins.b.word), .data_b_oe_o(oe_b),
		.over_range_flag_b_o(pins.b.over_range_flag), .over_range_flag_b_oe_o(fl_oe_b));
	capture_model capture_model_i (.clk_i, .hold_i(hold), .valid_i(valid_o), .pins_i(pins),
		.oe_a_i(oe_a), .ready_o(ready_i), .cap_o(cap));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic check(input logic [25:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic t_codes;
		logic [13:0] raw_t [7] = '{14'h1FFC, 14'h1000, 14'h0000, 14'h3000, 14'h2000, 14'h0002, 14'h0001};
		logic [12:0] exp_t [7] = '{13'h1FFE, 13'h1800, 13'h1000, 13'h0800, 13'h0000, 13'h1FFF, 13'h0001};
		for (int i = 0; i < 7; i++)
		begin
			samp_a_i = raw_t[i];
			samp_b_i = raw_t[6 - i];
			tick(4);
			check({pins.a, pins.b}, {exp_t[i], exp_t[6 - i]});
		end
		$display("coding test done");
	endtask : t_codes
	task automatic t_stall;
		adc_out_pkg::pair_s held;
		held = pins;
		hold = 1'b1;
		samp_a_i = 14'h0004;
		tick(6);
		check(pins, held);
		hold = 1'b0;
		tick(8);
		check(cap, {13'h0002, 13'h0FFE});
		$display("stall test done");
	endtask : t_stall
	task automatic t_freeze;
		adc_out_pkg::pair_s held;
		held = pins;
		ce_i = 1'b0;
		samp_a_i = 14'h3000;
		tick(4);
		check(pins, held);
		ce_i = 1'b1;
		tick(4);
		check({pins.a, pins.b}, {13'h0800, 13'h1FFE});
		$display("freeze test done");
	endtask : t_freeze
	task automatic t_oe;
		// flipped only while the stream is steady
		oe_a_n_i = 1'b1;
		oe_b_n_i = 1'b1;
		tick(2);
		check({fl_oe_a, fl_oe_b, oe_a, oe_b}, 26'h0000000);
		oe_a_n_i = 1'b0;
		oe_b_n_i = 1'b0;
		tick(2);
		check({fl_oe_a, fl_oe_b, oe_a, oe_b}, 26'h3FFFFFF);
		$display("enable test done");
	endtask : t_oe
	initial
		forever #5 clk_i = ~clk_i;
	initial
	begin
		tick(20);
		check({pins.a, pins.b}, {13'h1000, 13'h1000});
		reset_i = 1'b0;
		t_codes;
		t_stall;
		t_freeze;
		t_oe;
		report_and_stop;
	end
	// several times the expected run
	initial
	begin
		#5000;
		err_total++;
		report_and_stop;
	end
endmodule : testbench
